// File: logic/out_regs_pkg.sv
// package: address map, reset values and carriers of the output register bank
package out_regs_pkg;
   // ------------------------------------------------------------
   // word addresses (16-bit locations, pci lsb already dropped)
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam logic [15:0] MASK_ADDR = 16'h000A;
   localparam logic [15:0] FLAG_ADDR = 16'h000B;
   localparam logic [15:0] FRAME_CNT_ADDR = 16'h000C;
   localparam logic [15:0] REC_INV_LO_ADDR = 16'h1000;
   localparam logic [15:0] REC_INV_HI_ADDR = 16'h1001;
   localparam logic [15:0] IN_INV_LO_ADDR = 16'h1002;
   localparam logic [15:0] IN_INV_HI_ADDR = 16'h1003;
   localparam logic [15:0] RATE_ADDR = 16'h1004;
   localparam logic [15:0] TC_LO_ADDR = 16'h1005;
   localparam logic [15:0] TC_HI_ADDR = 16'h1006;
   localparam logic [15:0] ROLL_CNT_ADDR = 16'h1007;
   localparam logic [15:0] XBAR_BASE = 16'h2000;
   localparam logic [15:0] FORMAT_ADDR = 16'h2020;
   localparam logic [15:0] BANK_A_BASE = 16'h3000;
   localparam logic [15:0] BANK_B_BASE = 16'h3100;
   localparam logic [15:0] DLY_LO_ADDR = 16'h4000;
   localparam logic [15:0] DLY_HI_ADDR = 16'h4001;
   // ------------------------------------------------------------
   // sizes, field positions and reset values
   // ------------------------------------------------------------
   localparam int HDR_WORDS = 240;
   localparam int SLICES = 32;
   localparam int IRQ_BITS = 6;
   localparam int FMT_CODE_MSB = 2;
   localparam int FMT_ONE_BIT_POS = 15;
   localparam int RATE_MSB = 14;
   localparam logic [15:0] REC_INV_LO_RST = 16'h0055;
   localparam logic [15:0] REC_INV_HI_RST = 16'h00AA;
   localparam logic [15:0] IN_INV_LO_RST = 16'h0033;
   localparam logic [15:0] IN_INV_HI_RST = 16'h00CC;
   localparam logic [14:0] RATE_RST = 15'h0100;
   localparam logic [15:0] DLY_LO_RST = 16'h0000;
   // printed as five digits; the low sixteen bits are kept
   localparam logic [19:0] DLY_HI_PRINTED = 20'hF_FFF0;
   localparam logic [15:0] DLY_HI_RST = DLY_HI_PRINTED[15:0];
   // interrupt flag positions
   localparam int IRQ_SECOND = 0;
   localparam int IRQ_PPS = 1;
   localparam int IRQ_FRAME = 2;
   localparam int IRQ_SUMS = 3;
   localparam int IRQ_SYSPPS = 4;
   localparam int IRQ_PHASE = 5;

   // event strobes from the surrounding data path
   typedef struct packed {
      logic secondTick;
      logic sumsReady;
      logic systemPps;
      logic phaseCal;
   } evt_t;

   // host register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } host_req_t;

   // settings handed to the data path
   typedef struct packed {
      logic [31:0] recorderInvalid;
      logic [31:0] inputInvalid;
      logic [31:0] delayError;
      logic [2:0] laneFormatCode;
      logic singleBitSample;
   } cfg_t;
endpackage

// File: logic/output_path_register_bank.sv
// output path register bank: flags, strip header, crossbar, header rams
`timescale 1ns/100ps
module output_path_register_bank
   import out_regs_pkg::*;
#(
   parameter bit PHASE_CAL_BUILT = 1'b0,
   parameter int DATA_W = 32
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire host_req_t hostReq,
   output logic [15:0] hostRdata,
   output logic irqReq,
   input wire logic externalPps,
   input wire logic frameBoundary,
   input wire logic boundaryGenEnable,
   input wire evt_t events,
   input wire logic diskFrameDone,
   input wire logic [31:0] headerWord1,
   input wire logic [DATA_W-1:0] xbarIn,
   output logic [DATA_W-1:0] xbarOut,
   input wire logic [7:0] hdrIdx,
   input wire logic hdrBankSel,
   output logic [15:0] hdrWord,
   output cfg_t cfgOut,
   output logic [5:0] laneWidth
);
   // ------------------------------------------------------------
   // pin synchroniser and edge detect for the external pps
   // ------------------------------------------------------------
   logic ppsMeta_r;
   logic ppsSync_r;
   logic ppsLast_r;
   logic ppsTick;

   // first stage feeds only the second stage
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ppsMeta_r <= 1'b0;
         ppsSync_r <= 1'b0;
         ppsLast_r <= 1'b0;
      end else if (clkEn) begin
         ppsMeta_r <= externalPps;
         ppsSync_r <= ppsMeta_r;
         ppsLast_r <= ppsSync_r;
      end
   end
   assign ppsTick = ppsSync_r & ~ppsLast_r;

   // ------------------------------------------------------------
   // host decode
   // ------------------------------------------------------------
   logic rdEn;
   logic wrEn;
   logic inXbar;
   logic inBankA;
   logic inBankB;
   logic [4:0] sliceSel;
   logic [7:0] bankOff;

   assign rdEn = hostReq.rd & clkEn;
   assign wrEn = hostReq.wr & clkEn;
   assign sliceSel = hostReq.addr[4:0];
   assign bankOff = hostReq.addr[7:0];
   assign inXbar = hostReq.addr[15:5] == XBAR_BASE[15:5];
   assign inBankA = hostReq.addr[15:8] == BANK_A_BASE[15:8]
                    && bankOff < 8'(HDR_WORDS);
   assign inBankB = hostReq.addr[15:8] == BANK_B_BASE[15:8]
                    && bankOff < 8'(HDR_WORDS);

   // ------------------------------------------------------------
   // interrupt flags and mask
   // ------------------------------------------------------------
   logic [IRQ_BITS-1:0] flags_r;
   logic [IRQ_BITS-1:0] flags_nxt;
   logic [IRQ_BITS-1:0] mask_r;
   logic [IRQ_BITS-1:0] setVec;
   logic rollover;

   always_comb begin
      setVec = '0;
      setVec[IRQ_SECOND] = rollover;
      setVec[IRQ_PPS] = ppsTick;
      setVec[IRQ_FRAME] = frameBoundary;
      setVec[IRQ_SUMS] = events.sumsReady;
      setVec[IRQ_SYSPPS] = events.systemPps;
      setVec[IRQ_PHASE] = events.phaseCal & PHASE_CAL_BUILT;
   end

   // a set in the clearing cycle survives the read
   always_comb begin
      flags_nxt = flags_r;
      if (rdEn && hostReq.addr == FLAG_ADDR) begin
         flags_nxt = '0;
      end
      flags_nxt = flags_nxt | setVec;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags_r <= '0;
      end else if (clkEn) begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_r <= '0;
      end else if (wrEn && hostReq.addr == MASK_ADDR) begin
         mask_r <= hostReq.wdata[IRQ_BITS-1:0];
      end
   end

   assign irqReq = |(flags_r & mask_r);

   // ------------------------------------------------------------
   // frame boundary count
   // ------------------------------------------------------------
   logic [15:0] frameCnt_r;
   logic genSeen_r;

   // held at zero until the generator is first enabled
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frameCnt_r <= '0;
         genSeen_r <= 1'b0;
      end else if (clkEn) begin
         if (boundaryGenEnable) begin
            genSeen_r <= 1'b1;
         end
         if (!genSeen_r && boundaryGenEnable) begin
            frameCnt_r <= '0;
         end
         if (genSeen_r && frameBoundary) begin
            frameCnt_r <= frameCnt_r + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // strip header settings and counters
   // ------------------------------------------------------------
   logic [15:0] recLo_r;
   logic [15:0] recHi_r;
   logic [15:0] inLo_r;
   logic [15:0] inHi_r;
   logic [14:0] rate_r;
   logic [14:0] diskCnt_r;
   logic [31:0] timeCode_r;
   logic [15:0] rollCnt_r;

   // marker words, writable halves
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         recLo_r <= REC_INV_LO_RST;
         recHi_r <= REC_INV_HI_RST;
         inLo_r <= IN_INV_LO_RST;
         inHi_r <= IN_INV_HI_RST;
      end else if (wrEn) begin
         case (hostReq.addr)
            REC_INV_LO_ADDR: recLo_r <= hostReq.wdata;
            REC_INV_HI_ADDR: recHi_r <= hostReq.wdata;
            IN_INV_LO_ADDR: inLo_r <= hostReq.wdata;
            IN_INV_HI_ADDR: inHi_r <= hostReq.wdata;
            default: ;
         endcase
      end
   end

   // rate reads only; kept as a register so a default can be swapped
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rate_r <= RATE_RST;
      end else begin
         rate_r <= rate_r;
      end
   end

   // one-based rate: rollover after rate_r frames; zero treated as one
   assign rollover = diskFrameDone && clkEn
                     && (diskCnt_r + 15'h0001 >= rate_r);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         diskCnt_r <= '0;
         timeCode_r <= '0;
         rollCnt_r <= '0;
      end else if (clkEn && diskFrameDone) begin
         if (rollover) begin
            diskCnt_r <= '0;
            timeCode_r <= headerWord1;
            rollCnt_r <= rollCnt_r + 16'h0001;
         end else begin
            diskCnt_r <= diskCnt_r + 15'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // crossbar slices and format
   // ------------------------------------------------------------
   logic [4:0] slice_r [SLICES];
   logic [15:0] format_r;

   genvar gi;
   generate
      for (gi = 0; gi < SLICES; gi++) begin : g_slice
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               slice_r[gi] <= 5'(gi);
            end else if (wrEn && inXbar && sliceSel == 5'(gi)) begin
               slice_r[gi] <= hostReq.wdata[4:0];
            end
         end
         // registered so the output is a flip-flop
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               xbarOut[gi] <= 1'b0;
            end else if (clkEn) begin
               xbarOut[gi] <= xbarIn[slice_r[gi]];
            end
         end
      end
   endgenerate

   // only code and sample flag are stored; middle bits read zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         format_r <= '0;
      end else if (wrEn && hostReq.addr == FORMAT_ADDR) begin
         format_r <= '0;
         format_r[FMT_CODE_MSB:0] <= hostReq.wdata[FMT_CODE_MSB:0];
         format_r[FMT_ONE_BIT_POS] <= hostReq.wdata[FMT_ONE_BIT_POS];
      end
   end

   // width 32 >> code; undefined codes give zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         laneWidth <= 6'h20;
      end else if (clkEn) begin
         case (format_r[FMT_CODE_MSB:0])
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
               laneWidth <= 6'h20 >> format_r[FMT_CODE_MSB:0];
            default: laneWidth <= 6'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // header banks
   // ------------------------------------------------------------
   logic [15:0] bankA [HDR_WORDS];
   logic [15:0] bankB [HDR_WORDS];
   logic [15:0] bankRd_r;

   // no reset on ram contents; software preloads them
   always_ff @(posedge clock) begin
      if (wrEn && inBankA) begin
         bankA[bankOff] <= hostReq.wdata;
      end
      if (wrEn && inBankB) begin
         bankB[bankOff] <= hostReq.wdata;
      end
   end

   // data path port: bank B for even frames (sel high)
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hdrWord <= '0;
      end else if (clkEn && hdrIdx < 8'(HDR_WORDS)) begin
         hdrWord <= hdrBankSel ? bankB[hdrIdx] : bankA[hdrIdx];
      end
   end

   // ------------------------------------------------------------
   // delay error
   // ------------------------------------------------------------
   logic [15:0] dlyLo_r;
   logic [15:0] dlyHi_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dlyLo_r <= DLY_LO_RST;
         dlyHi_r <= DLY_HI_RST;
      end else if (wrEn && hostReq.addr == DLY_LO_ADDR) begin
         dlyLo_r <= hostReq.wdata;
      end else if (wrEn && hostReq.addr == DLY_HI_ADDR) begin
         dlyHi_r <= hostReq.wdata;
      end
   end

   always_comb begin
      cfgOut.recorderInvalid = {recHi_r, recLo_r};
      cfgOut.inputInvalid = {inHi_r, inLo_r};
      cfgOut.delayError = {dlyHi_r, dlyLo_r};
      cfgOut.laneFormatCode = format_r[FMT_CODE_MSB:0];
      cfgOut.singleBitSample = format_r[FMT_ONE_BIT_POS];
   end

   // ------------------------------------------------------------
   // read mux, registered: data one cycle after the read strobe
   // ------------------------------------------------------------
   logic [15:0] rdMux;

   always_comb begin
      rdMux = '0;
      bankRd_r = '0;
      if (inBankA) begin
         bankRd_r = bankA[bankOff];
      end else if (inBankB) begin
         bankRd_r = bankB[bankOff];
      end
      if (inXbar) begin
         rdMux = {11'h000, slice_r[sliceSel]};
      end else if (inBankA || inBankB) begin
         rdMux = bankRd_r;
      end else begin
         case (hostReq.addr)
            MASK_ADDR: rdMux = {10'h000, mask_r};
            FLAG_ADDR: rdMux = {10'h000, flags_r};
            FRAME_CNT_ADDR: rdMux = frameCnt_r;
            REC_INV_LO_ADDR: rdMux = recLo_r;
            REC_INV_HI_ADDR: rdMux = recHi_r;
            IN_INV_LO_ADDR: rdMux = inLo_r;
            IN_INV_HI_ADDR: rdMux = inHi_r;
            RATE_ADDR: rdMux = {1'b0, rate_r};
            TC_LO_ADDR: rdMux = timeCode_r[15:0];
            TC_HI_ADDR: rdMux = timeCode_r[31:16];
            ROLL_CNT_ADDR: rdMux = rollCnt_r;
            FORMAT_ADDR: rdMux = format_r;
            DLY_LO_ADDR: rdMux = dlyLo_r;
            DLY_HI_ADDR: rdMux = dlyHi_r;
            default: rdMux = '0;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hostRdata <= '0;
      end else if (rdEn) begin
         hostRdata <= rdMux;
      end
   end
endmodule // output_path_register_bank

// File: testbench/opb_checker.sv
// checker: port relations of the output register bank
`timescale 1ns/100ps
module opb_checker
   import out_regs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire host_req_t hostReq,
   input wire logic [15:0] hostRdata,
   input wire cfg_t cfgOut,
   input wire logic [5:0] laneWidth
);
   // ------------------------------------------------------------
   // clocking and helpers
   // ------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // a write or read strobe that the bank really takes
   logic wrOk;
   logic rdOk;
   assign wrOk = clkEn && hostReq.wr;
   assign rdOk = clkEn && hostReq.rd;
   // ------------------------------------------------------------
   // marker and delay words follow their writes
   // ------------------------------------------------------------
   property p_rec_lo;
      wrOk && hostReq.addr == REC_INV_LO_ADDR |=>
         cfgOut.recorderInvalid[15:0] == $past(hostReq.wdata);
   endproperty
   a_rec_lo: assert property (p_rec_lo)
      else $error("recorder marker low not written");
   property p_in_lo;
      wrOk && hostReq.addr == IN_INV_LO_ADDR |=>
         cfgOut.inputInvalid[15:0] == $past(hostReq.wdata);
   endproperty
   a_in_lo: assert property (p_in_lo)
      else $error("input marker low not written");
   property p_in_hi;
      wrOk && hostReq.addr == IN_INV_HI_ADDR |=>
         cfgOut.inputInvalid[31:16] == $past(hostReq.wdata);
   endproperty
   a_in_hi: assert property (p_in_hi)
      else $error("input marker high not written");
   property p_dly_hi;
      wrOk && hostReq.addr == DLY_HI_ADDR |=>
         cfgOut.delayError[31:16] == $past(hostReq.wdata);
   endproperty
   a_dly_hi: assert property (p_dly_hi)
      else $error("delay error high not written");
   // ------------------------------------------------------------
   // format field and lane width
   // ------------------------------------------------------------
   property p_fmt;
      wrOk && hostReq.addr == FORMAT_ADDR |=>
         cfgOut.laneFormatCode == $past(hostReq.wdata[2:0]) &&
         cfgOut.singleBitSample == $past(hostReq.wdata[15]);
   endproperty
   a_fmt: assert property (p_fmt)
      else $error("format register not written");
   // code held two samples, so the registered width has caught up
   property p_lane;
      clkEn && cfgOut.laneFormatCode <= 3'd5 ##1
         $stable(cfgOut.laneFormatCode) |->
         laneWidth == (6'd32 >> cfgOut.laneFormatCode);
   endproperty
   a_lane: assert property (p_lane)
      else $error("lane width does not match code");
   property p_lane_bad;
      clkEn && cfgOut.laneFormatCode > 3'd5 ##1
         $stable(cfgOut.laneFormatCode) |-> laneWidth == 6'd0;
   endproperty
   a_lane_bad: assert property (p_lane_bad)
      else $error("undefined code gives nonzero width");
   // ------------------------------------------------------------
   // read-only frame rate
   // ------------------------------------------------------------
   property p_rate;
      rdOk && hostReq.addr == RATE_ADDR |=>
         hostRdata == 16'h0100;
   endproperty
   a_rate: assert property (p_rate)
      else $error("frame rate read wrong");
endmodule // opb_checker

bind output_path_register_bank opb_checker chk_u (
   .clock(clock),
   .rst(rst),
   .clkEn(clkEn),
   .hostReq(hostReq),
   .hostRdata(hostRdata),
   .cfgOut(cfgOut),
   .laneWidth(laneWidth)
);

// File: testbench/host_model.sv
// host software model: word reads and writes to the register bank
`timescale 1ns/100ps
module host_model
   import out_regs_pkg::*;
(
   input wire logic clock,
   input wire logic [15:0] hostRdata,
   output host_req_t hostReq
);
   // ------------------------------------------------------------
   // one bus cycle
   // ------------------------------------------------------------
   // request held over the taking edge, then a quiet cycle so two
   // calls never touch the strobe in one time step
   initial hostReq = '0;
   task automatic access(input logic rd, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q);
      hostReq = '{rd: rd, wr: !rd, addr: a, wdata: d};
      @(posedge clock);
      #1 hostReq = '0;
      q = hostRdata;
      @(posedge clock);
      #1;
   endtask
endmodule // host_model

// File: testbench/test_output_path_register_bank.sv
// testbench: scenarios for the output register bank
`timescale 1ns/100ps
module test_output_path_register_bank
   import out_regs_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   host_req_t hostReq;
   logic [15:0] hostRdata;
   logic irqReq;
   logic externalPps = 1'b0;
   logic frameBoundary = 1'b0;
   logic boundaryGenEnable = 1'b0;
   evt_t events = '0;
   logic diskFrameDone = 1'b0;
   logic [31:0] headerWord1 = 32'h1234_5678;
   logic [31:0] xbarIn = 32'h8000_0000;
   logic [31:0] xbarOut;
   logic [7:0] hdrIdx = 8'h00;
   logic hdrBankSel = 1'b0;
   logic [15:0] hdrWord;
   cfg_t cfgOut;
   logic [5:0] laneWidth;
   int n_fail = 0;
   int n_checks = 0;
   // ------------------------------------------------------------
   // design, host and clock
   // ------------------------------------------------------------
   output_path_register_bank dut_u (.clock(clock), .rst(rst),
      .clkEn(clkEn), .hostReq(hostReq), .hostRdata(hostRdata),
      .irqReq(irqReq), .externalPps(externalPps),
      .frameBoundary(frameBoundary),
      .boundaryGenEnable(boundaryGenEnable), .events(events),
      .diskFrameDone(diskFrameDone), .headerWord1(headerWord1),
      .xbarIn(xbarIn), .xbarOut(xbarOut), .hdrIdx(hdrIdx),
      .hdrBankSel(hdrBankSel), .hdrWord(hdrWord), .cfgOut(cfgOut),
      .laneWidth(laneWidth));
   host_model host_u (.clock(clock), .hostRdata(hostRdata),
      .hostReq(hostReq));
   initial forever #12.5 clock = ~clock;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] q;
      host_u.access(1'b0, a, d, q);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] q;
      host_u.access(1'b1, a, 16'h0000, q);
      chk({16'h0000, q}, {16'h0000, e});
   endtask
   // wait n edges, land just after the last one
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic end_of_test;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset;
      rdc(REC_INV_LO_ADDR, 16'h0055);
      rdc(REC_INV_HI_ADDR, 16'h00AA);
      rdc(IN_INV_LO_ADDR, 16'h0033);
      rdc(IN_INV_HI_ADDR, 16'h00CC);
      rdc(RATE_ADDR, 16'h0100);
      rdc(ROLL_CNT_ADDR, 16'h0000);
      rdc(FRAME_CNT_ADDR, 16'h0000);
      rdc(DLY_LO_ADDR, 16'h0000);
      rdc(DLY_HI_ADDR, 16'hFFF0);
      rdc(XBAR_BASE + 16'd5, 16'h0005);
      chk(xbarOut, 32'h8000_0000);
      $display("test_reset done");
   endtask
   task automatic test_write;
      wr(REC_INV_LO_ADDR, 16'h1357);
      wr(IN_INV_LO_ADDR, 16'h1357);
      wr(IN_INV_HI_ADDR, 16'h2468);
      wr(DLY_LO_ADDR, 16'h0001);
      wr(DLY_HI_ADDR, 16'hFFFE);
      chk(cfgOut.recorderInvalid, 32'h00AA_1357);
      chk(cfgOut.inputInvalid, 32'h2468_1357);
      chk(cfgOut.delayError, 32'hFFFE_0001);
      wr(RATE_ADDR, 16'h0005);
      rdc(RATE_ADDR, 16'h0100);
      rdc(16'h0FFF, 16'h0000);
      $display("test_write done");
   endtask
   task automatic test_xbar_format;
      wr(XBAR_BASE, 16'h001F);
      step(2);
      chk(xbarOut, 32'h8000_0001);
      rdc(XBAR_BASE, 16'h001F);
      for (int c = 0; c < 8; c++) begin
         wr(FORMAT_ADDR, {c[0], 12'h000, c[2:0]});
         step(2);
         chk({26'h0, laneWidth}, c < 6 ? 32'd32 >> c : 32'd0);
         chk({31'h0, cfgOut.singleBitSample}, {31'h0, c[0]});
      end
      $display("test_xbar_format done");
   endtask
   task automatic test_banks;
      wr(BANK_A_BASE + 16'd3, 16'hA5A5);
      wr(BANK_B_BASE + 16'd3, 16'h5A5A);
      wr(BANK_A_BASE + 16'd239, 16'h1234);
      wr(BANK_A_BASE + 16'd240, 16'hFFFF);
      hdrIdx = 8'd3;
      step(2);
      chk({16'h0, hdrWord}, 32'h0000_A5A5);
      hdrBankSel = 1'b1;
      step(2);
      chk({16'h0, hdrWord}, 32'h0000_5A5A);
      rdc(BANK_A_BASE + 16'd239, 16'h1234);
      rdc(BANK_A_BASE + 16'd240, 16'h0000);
      rdc(BANK_B_BASE + 16'd3, 16'h5A5A);
      $display("test_banks done");
   endtask
   task automatic test_flags;
      wr(MASK_ADDR, 16'h003F);
      boundaryGenEnable = 1'b1;
      step(1);
      frameBoundary = 1'b1;
      events = '{secondTick: 0, sumsReady: 1, systemPps: 1, phaseCal: 1};
      externalPps = 1'b1;
      step(1);
      frameBoundary = 1'b0;
      events = '0;
      step(4);
      externalPps = 1'b0;
      chk({31'h0, irqReq}, 32'd1);
      rdc(FLAG_ADDR, 16'h001E);
      rdc(FLAG_ADDR, 16'h0000);
      chk({31'h0, irqReq}, 32'd0);
      rdc(FRAME_CNT_ADDR, 16'h0001);
      wr(MASK_ADDR, 16'h0000);
      events.systemPps = 1'b1;
      step(1);
      events = '0;
      step(1);
      chk({31'h0, irqReq}, 32'd0);
      wr(MASK_ADDR, 16'h0010);
      chk({31'h0, irqReq}, 32'd1);
      rdc(FLAG_ADDR, 16'h0010);
      $display("test_flags done");
   endtask
   // the rate field holds 256, so the 256th frame rolls over
   task automatic test_rollover;
      wr(MASK_ADDR, 16'h0001);
      repeat (255) begin
         diskFrameDone = 1'b1;
         step(1);
         diskFrameDone = 1'b0;
         step(1);
      end
      rdc(ROLL_CNT_ADDR, 16'h0000);
      headerWord1 = 32'h9ABC_DEF0;
      diskFrameDone = 1'b1;
      step(1);
      diskFrameDone = 1'b0;
      step(1);
      chk({31'h0, irqReq}, 32'd1);
      rdc(TC_LO_ADDR, 16'hDEF0);
      rdc(TC_HI_ADDR, 16'h9ABC);
      rdc(ROLL_CNT_ADDR, 16'h0001);
      rdc(FLAG_ADDR, 16'h0001);
      $display("test_rollover done");
   endtask
   // enable low: a write strobe and an event both go unseen
   task automatic test_clk_enable;
      clkEn = 1'b0;
      events.systemPps = 1'b1;
      wr(REC_INV_HI_ADDR, 16'hBEEF);
      events = '0;
      clkEn = 1'b1;
      chk(cfgOut.recorderInvalid, 32'h00AA_1357);
      rdc(FLAG_ADDR, 16'h0000);
      $display("test_clk_enable done");
   endtask
   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      #1 rst = 1'b0;
      test_reset;
      test_write;
      test_xbar_format;
      test_banks;
      test_flags;
      test_rollover;
      test_clk_enable;
      end_of_test;
   end
   initial begin
      #200_000;
      n_fail++;
      end_of_test;
   end
endmodule // test_output_path_register_bank
